// ===== logic/bcp_host_codec.v
// host side command packet builder and response packet parser
// assumes a byte stream toward and from a framing layer on clk_sys
// Operation
// - packet is header then 32-bit words
// - at most seven parameter words
// - header bytes: tag, flags, reserved, count
// - reserved header byte sent as zero
// - word count equals count byte
// - command tags 0x01 through 0x09, except 0x06
// - command tags 0x0a through 0x10
// - flag bit 0 announces data phase
// - data length comes from a parameter
// - packets ride inside framing packets
// - frame type a4 command, a5 data; tx_frame_type_ff is always a4, no data frame is sent
`timescale 1ns/10ps
`default_nettype none
`include "bcp_defines.vh"
module bcp_host_codec #(
  parameter MAX_PARAMS = 7
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [7:0]  cmd_tag,
  input  wire        cmd_has_data,
  input  wire [3:0]  cmd_count,
  input  wire        par_wr,
  input  wire [2:0]  par_idx,
  input  wire [31:0] par_word,
  input  wire [2:0]  data_len_idx,
  output reg  [31:0] data_len_ff,
  output reg         cmd_err_ff,
  output reg  [7:0]  tx_byte_ff,
  output reg         tx_valid_ff,
  output reg         tx_first_ff,
  output reg  [7:0]  tx_frame_type_ff,
  output reg  [15:0] tx_length_ff,
  input  wire        tx_ready,
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  input  wire        rx_first,
  output reg  [7:0]  rsp_tag_ff,
  output reg         rsp_has_data_ff,
  output reg  [31:0] rsp_status_ff,
  output reg  [31:0] rsp_word1_ff,
  output reg         rsp_done_ff,
  output reg         rsp_bad_ff
);
  localparam ST_IDLE = 2'b00;
  localparam ST_HDR  = 2'b01;
  localparam ST_PAR  = 2'b10;
  localparam ST_RD   = 2'b11;

  reg  [1:0]  st_ff;
  reg  [1:0]  byte_ff;
  reg  [2:0]  word_ff;
  reg  [3:0]  cnt_ff;
  reg  [31:0] hdr_ff;
  reg  [7:0]  exp_tag_ff;
  reg  [2:0]  len_idx_ff;
  reg  [2:0]  rd_addr;
  wire [31:0] rd_word;
  wire        tag_ok;

  localparam [3:0] MAX_CNT = MAX_PARAMS[3:0];

  // command tag legal: 0x01..0x10 minus reserved 0x06, 0x11 reserved
  assign tag_ok = (cmd_tag >= `BCP_TAG_FIRST_CMD) && (cmd_tag <= `BCP_TAG_FLASH_RES) &&
                  (cmd_tag != `BCP_TAG_LIFT_LOCK);
  // a new command waits until the last byte of the previous one has gone
  assign cmd_ready = (st_ff == ST_IDLE) && !tx_valid_ff;

  bcp_param_mem #(.DEPTH(8), .AWIDTH(3)) u_mem (
    .clk_sys    (clk_sys),
    .wr_en      (par_wr & cmd_ready),
    .wr_addr    (par_idx),
    .wr_data    (par_word),
    .rd_addr    (rd_addr),
    .rd_data_ff (rd_word)
  );

  // read address: length word while the header goes out, else next parameter
  always @* begin
    if (st_ff == ST_HDR) begin
      rd_addr = len_idx_ff;
    end else begin
      rd_addr = word_ff;
    end
  end

  // transmit sequencer: header bytes then parameter words, lsb first
  always @(posedge clk_sys) begin
    if (!resetn) begin
      st_ff <= ST_IDLE;
      byte_ff <= 2'b00;
      word_ff <= 3'b000;
      cnt_ff <= 4'h0;
      hdr_ff <= 32'h0000_0000;
      tx_byte_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_first_ff <= 1'b0;
      tx_frame_type_ff <= `BCP_FRAME_CMD;
      tx_length_ff <= 16'h0000;
      cmd_err_ff <= 1'b0;
      data_len_ff <= 32'h0000_0000;
      exp_tag_ff <= 8'h00;
      len_idx_ff <= 3'b000;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          tx_valid_ff <= 1'b0;
          tx_first_ff <= 1'b0;
          if (cmd_valid) begin
            if (!tag_ok || cmd_count > MAX_CNT) begin
              cmd_err_ff <= 1'b1;
            end else begin
              cmd_err_ff <= 1'b0;
              hdr_ff[`BCP_HDR_TAG_LSB +: 8] <= cmd_tag;
              hdr_ff[`BCP_HDR_FLAGS_LSB +: 8] <= {7'h00, cmd_has_data};
              hdr_ff[`BCP_HDR_RSVD_LSB +: 8] <= `BCP_RSVD_VALUE;
              hdr_ff[`BCP_HDR_CNT_LSB +: 8] <= {4'h0, cmd_count};
              cnt_ff <= cmd_count;
              exp_tag_ff <= cmd_tag;
              len_idx_ff <= data_len_idx;
              tx_frame_type_ff <= `BCP_FRAME_CMD;
              tx_length_ff <= `BCP_HDR_BYTES + {10'h000, cmd_count, 2'b00};
              byte_ff <= 2'b00;
              word_ff <= 3'b000;
              st_ff <= ST_HDR;
            end
          end
        end
        ST_HDR: begin
          // length word was read on the first header edge, stable from then on
          if (tx_valid_ff) begin
            data_len_ff <= hdr_ff[`BCP_HDR_FLAGS_LSB + `BCP_FLAG_DATA_BIT] ?
                           rd_word : 32'h0000_0000;
          end
          if (!tx_valid_ff || tx_ready) begin
            tx_valid_ff <= 1'b1;
            tx_first_ff <= (byte_ff == 2'b00) && !tx_valid_ff;
            tx_byte_ff <= hdr_ff[{byte_ff, 3'b000} +: 8];
            byte_ff <= byte_ff + 2'b01;
            if (byte_ff == 2'b11) begin
              st_ff <= (cnt_ff == 4'h0) ? ST_IDLE : ST_RD;
            end
          end
        end
        ST_RD: begin
          // wait until the last byte is taken, which also covers the registered memory read
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            tx_first_ff <= 1'b0;
            st_ff <= ST_PAR;
          end
        end
        ST_PAR: begin
          tx_valid_ff <= 1'b1;
          tx_first_ff <= 1'b0;
          if (!tx_valid_ff || tx_ready) begin
            tx_byte_ff <= rd_word[{byte_ff, 3'b000} +: 8];
            byte_ff <= byte_ff + 2'b01;
            if (byte_ff == 2'b11) begin
              if ({1'b0, word_ff} + 4'h1 == cnt_ff) begin
                st_ff <= ST_IDLE;
              end else begin
                word_ff <= word_ff + 3'b001;
                st_ff <= ST_RD;
              end
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      if (st_ff == ST_IDLE && tx_valid_ff && !tx_ready) begin
        tx_valid_ff <= 1'b1;
      end
    end
  end

  reg  [4:0]  rx_pos_ff;
  reg  [3:0]  rx_cnt_ff;
  wire [4:0]  pos;
  wire [2:0]  wsel;
  assign pos  = rx_first ? 5'h00 : rx_pos_ff;
  assign wsel = pos[4:2];

  // receive parser: reply header, status word, second word, checks
  always @(posedge clk_sys) begin
    if (!resetn) begin
      rx_pos_ff <= 5'h00;
      rx_cnt_ff <= 4'h0;
      rsp_tag_ff <= 8'h00;
      rsp_has_data_ff <= 1'b0;
      rsp_status_ff <= 32'h0000_0000;
      rsp_word1_ff <= 32'h0000_0000;
      rsp_done_ff <= 1'b0;
      rsp_bad_ff <= 1'b0;
    end else begin
      rsp_done_ff <= 1'b0;
      if (rx_valid) begin
        rx_pos_ff <= pos + 5'h01;
        if (wsel == 3'b000) begin
          case (pos[1:0])
            2'b00: rsp_tag_ff <= rx_byte;
            2'b01: rsp_has_data_ff <= rx_byte[`BCP_FLAG_DATA_BIT];
            2'b10: rsp_bad_ff <= 1'b0;
            default: rx_cnt_ff <= rx_byte[3:0];
          endcase
          if (pos[1:0] == 2'b11 && rx_byte == 8'h00) begin
            rsp_done_ff <= 1'b1;
          end
          if (pos[1:0] == 2'b11 && rx_byte > {4'h0, MAX_CNT}) begin
            rsp_bad_ff <= 1'b1;
          end
        end else if (wsel == 3'b001) begin
          rsp_status_ff[{pos[1:0], 3'b000} +: 8] <= rx_byte;
        end else if (wsel == 3'b010) begin
          rsp_word1_ff[{pos[1:0], 3'b000} +: 8] <= rx_byte;
        end
        if (pos[1:0] == 2'b11 && wsel != 3'b000 && {1'b0, wsel} == rx_cnt_ff) begin
          rsp_done_ff <= 1'b1;
          // reply tag must match the command it answers, except plain 0xa0 which needs a word count of 2
          case (rsp_tag_ff)
            `BCP_TAG_PLAIN: rsp_bad_ff <= (rx_cnt_ff != 4'h2);
            `BCP_TAG_MEM_FETCH: rsp_bad_ff <= (exp_tag_ff != `BCP_TAG_FETCH_MEM);
            `BCP_TAG_QUERY: rsp_bad_ff <= (exp_tag_ff != `BCP_TAG_QUERY_SET);
            `BCP_TAG_OTP_READ: rsp_bad_ff <= (exp_tag_ff != `BCP_TAG_READ_OTP);
            `BCP_TAG_RES_READ: rsp_bad_ff <= (exp_tag_ff != `BCP_TAG_FLASH_RES);
            default: rsp_bad_ff <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule // bcp_host_codec
`default_nettype wire

// ===== logic/bcp_param_mem.v
// parameter word store of the packet codec
// assumes one clock; write and registered read ports
`timescale 1ns/10ps
`default_nettype none
module bcp_param_mem #(
  parameter DEPTH  = 8,
  parameter AWIDTH = 3
) (
  input  wire              clk_sys,
  input  wire              wr_en,
  input  wire [AWIDTH-1:0] wr_addr,
  input  wire [31:0]       wr_data,
  input  wire [AWIDTH-1:0] rd_addr,
  output reg  [31:0]       rd_data_ff
);
  reg [31:0] mem [0:DEPTH-1];

  // write and registered read
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // bcp_param_mem
`default_nettype wire

// ===== shared/bcp_defines.vh
// constants of the boot command packet codec
// assumes inclusion by bare name from the design files
`ifndef BCP_DEFINES_VH
`define BCP_DEFINES_VH
`define BCP_HDR_TAG_LSB     0
`define BCP_HDR_FLAGS_LSB   8
`define BCP_HDR_RSVD_LSB    16
`define BCP_HDR_CNT_LSB     24
`define BCP_RSVD_VALUE      8'h00
`define BCP_FLAG_DATA_BIT   0
`define BCP_MAX_PARAMS      4'h7
`define BCP_HDR_BYTES       16'h0004
`define BCP_FRAME_START     8'h5a
`define BCP_FRAME_CMD       8'ha4
`define BCP_FRAME_DATA      8'ha5
`define BCP_TAG_FIRST_CMD   8'h01
`define BCP_TAG_LIFT_LOCK   8'h06
`define BCP_TAG_FLASH_RES   8'h10
`define BCP_TAG_RSVD_11     8'h11
`define BCP_TAG_PLAIN       8'ha0
`define BCP_TAG_MEM_FETCH   8'ha3
`define BCP_TAG_QUERY       8'ha7
`define BCP_TAG_OTP_READ    8'haf
`define BCP_TAG_RES_READ    8'hb0
`define BCP_TAG_FETCH_MEM   8'h03
`define BCP_TAG_QUERY_SET   8'h07
`define BCP_TAG_READ_OTP    8'h0f
`endif

// ===== tb/bcp_host_codec_sva.sv
// port checks for the host packet codec
// assumes a bind onto bcp_host_codec, one clock
`timescale 1ns/10ps
`default_nettype none
module bcp_host_codec_sva #(parameter MAX_PARAMS = 7) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_tag,
  input wire logic        cmd_has_data,
  input wire logic [3:0]  cmd_count,
  input wire logic [7:0]  tx_byte_ff,
  input wire logic        tx_valid_ff,
  input wire logic        tx_first_ff,
  input wire logic [15:0] tx_length_ff,
  input wire logic        tx_ready
);
  logic [7:0] tag_ff;
  logic [3:0] cnt_ff;
  logic       hd_ff;
  logic [5:0] pos_ff;
  wire t = cmd_valid && cmd_ready;
  wire h = tx_valid_ff && !tx_first_ff;
  wire ok = cmd_tag != 8'h00 && cmd_tag != 8'h06 && cmd_tag <= 8'h10 && cmd_count <= MAX_PARAMS;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // copy of the request and count of bytes taken
  always @(posedge clk_sys) begin
    if (t) {tag_ff, cnt_ff, hd_ff} <= {cmd_tag, cmd_count, cmd_has_data};
    if (!resetn) pos_ff <= 6'h00;
    else if (tx_valid_ff && tx_ready) pos_ff <= tx_first_ff ? 6'h01 : pos_ff + 6'h01;
  end
  a_hdr_start: assert property (t && ok |-> ##[1:2] tx_valid_ff && tx_first_ff)
    else $error("no header");
  a_bad_quiet: assert property (t && !ok |=> !tx_valid_ff [*3])
    else $error("bad sent");
  a_first_tag: assert property (tx_valid_ff && tx_first_ff |-> tx_byte_ff == tag_ff)
    else $error("tag");
  a_frame_len: assert property (tx_valid_ff && tx_first_ff |-> tx_length_ff == 16'h0004 + 16'h0004 * cnt_ff)
    else $error("length");
  a_flag_bit: assert property (h && pos_ff == 6'h01 |-> tx_byte_ff == {7'h00, hd_ff})
    else $error("flags");
  a_rsvd_zero: assert property (h && pos_ff == 6'h02 |-> tx_byte_ff == 8'h00)
    else $error("rsvd");
  a_count_byte: assert property (h && pos_ff == 6'h03 |-> tx_byte_ff == {4'h0, cnt_ff})
    else $error("count");
  a_byte_hold: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_byte_ff))
    else $error("hold");
  c_bad: cover property (t && !ok);
  c_full: cover property (t && ok && cmd_count == 4'h7);
  c_stall: cover property (tx_valid_ff && !tx_ready);
endmodule // bcp_host_codec_sva
bind bcp_host_codec bcp_host_codec_sva #(.MAX_PARAMS(MAX_PARAMS)) bcp_host_codec_sva_inst (.*);
`default_nettype wire

// ===== tb/bcp_target_model.sv
// target stand-in: takes a command packet, answers a reply packet
// assumes the codec byte streams on clk_sys
`timescale 1ns/10ps
`default_nettype none
module bcp_target_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  input  wire logic        tx_first,
  input  wire logic [15:0] tx_length,
  input  wire logic        lie,
  output var  logic        tx_ready,
  output var  logic [7:0]  rx_byte,
  output var  logic        rx_valid,
  output var  logic        rx_first
);
  logic [7:0] g;
  int         n, i;
  // random stall on intake, reply once the whole packet is in
  initial begin
    {tx_ready, rx_valid, rx_first, rx_byte, n} = 0;
    forever begin
      @(posedge clk_sys);
      if (tx_valid && tx_ready) n = tx_first ? 1 : n + 1;
      if (tx_valid && tx_ready && tx_first) g = tx_byte;
      #1;
      rx_byte = ~rx_byte; // idle line keeps moving
      tx_ready = 1'($urandom);
      if (n != 0 && n == tx_length) begin
        n = 0;
        tx_ready = 0;
        for (i = 0; i < 12; i++) begin
          {rx_valid, rx_first} = {1'b1, i == 0};
          rx_byte = i == 0 ? (lie ? 8'ha3 : g == 8'h07 ? 8'ha7 : 8'ha0)
                  : i == 3 ? 8'h02 : i == 8 ? g : 8'h00;
          @(posedge clk_sys);
          #1;
        end
        {rx_valid, rx_first} = 0;
      end
    end
  end
endmodule // bcp_target_model
`default_nettype wire

// ===== tb/test_boot_command_packet_codec.sv
// bench for the host codec against the target model
// assumes the checker is bound onto the codec
`timescale 1ns/10ps
`default_nettype none
module test_boot_command_packet_codec;
  logic        clk_sys, resetn, cmd_valid, cmd_ready, cmd_has_data, par_wr, tx_ready, rx_valid;
  logic        rx_first, tx_valid_ff, tx_first_ff, cmd_err_ff, rsp_has_data_ff, rsp_done_ff, rsp_bad_ff;
  logic        lie;
  logic [2:0]  par_idx, data_len_idx;
  logic [3:0]  cmd_count;
  logic [7:0]  cmd_tag, tx_byte_ff, tx_frame_type_ff, rx_byte, rsp_tag_ff;
  logic [15:0] tx_length_ff;
  logic [31:0] par_word, data_len_ff, rsp_status_ff, rsp_word1_ff, prm [0:7];
  int          fail_count, tests_run, cyc, t;
  bcp_host_codec bcp_host_codec_inst (.*);
  bcp_target_model bcp_target_model_inst (.clk_sys, .tx_byte(tx_byte_ff), .tx_valid(tx_valid_ff),
    .tx_first(tx_first_ff), .tx_length(tx_length_ff), .tx_ready, .rx_byte, .rx_valid, .rx_first,
    .lie);
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  // load words, issue one command, judge the outcome
  task automatic run(logic [7:0] g, logic d, logic [3:0] c);
    int         i;
    logic [2:0] x;
    x = 3'($urandom);
    for (i = 0; i < 300 && cmd_ready !== 1'b1; i++) tick;
    for (i = 0; i < 8; i++) begin
      prm[i] = $urandom;
      {par_wr, par_idx, par_word} = {1'b1, i[2:0], prm[i]};
      tick;
    end
    {par_wr, cmd_valid, cmd_tag, cmd_has_data, cmd_count, data_len_idx} = {2'h1, g, d, c, x};
    tick;
    cmd_valid = 0;
    tick;
    tick;
    if (g == 8'h00 || g == 8'h06 || g > 8'h10 || c > 4'h7) begin
      chk("cmd_err_ff", 1, cmd_err_ff);
    end else begin
      for (i = 0; i < 400 && rsp_done_ff !== 1'b1; i++) tick;
      chk("rsp_done_ff", 1, rsp_done_ff);
      chk("rsp_tag_ff", lie ? 8'ha3 : g == 8'h07 ? 8'ha7 : 8'ha0, rsp_tag_ff);
      chk("rsp_bad_ff", lie && g != 8'h03, rsp_bad_ff);
      chk("rsp_status_ff", 0, rsp_status_ff);
      chk("rsp_has_data_ff", 0, rsp_has_data_ff);
      chk("cmd_err_ff", 0, cmd_err_ff);
      chk("rsp_word1_ff", g, rsp_word1_ff);
      chk("data_len_ff", d ? prm[x] : 0, data_len_ff);
      chk("tx_frame_type_ff", 8'ha4, tx_frame_type_ff);
    end
  endtask
  // clock
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  // cycle ceiling
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_of_test;
    end
  end
  // reset, tags 0x00 through 0x12, then random traffic
  initial begin
    {resetn, cmd_valid, cmd_tag, cmd_has_data, cmd_count, par_wr, par_idx, par_word, data_len_idx} = 0;
    lie = 0;
    void'($urandom(87));
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1;
    for (t = 0; t < 19; t++) run(t, 1'($urandom), 4'($urandom_range(0, 7)));
    run(8'h04, 1, 4'h7);
    lie = 1;
    run(8'h07, 0, 4'h1);
    run(8'h03, 0, 4'h2);
    lie = 0;
    for (t = 0; t < 20; t++) run(8'($urandom), 1, 4'($urandom_range(0, 8)));
    end_of_test;
  end
endmodule // test_boot_command_packet_codec
`default_nettype wire
